// [logic/pim_pkg.sv]
// shared constants and types of the pin interrupt and pattern match engine
package pim_pkg;

  // ********************************************************************
  // sizes
  // ********************************************************************
  localparam int NUM_CH  = 8;
  localparam int NUM_PAD = 18;
  localparam int SEL_W   = 5;
  localparam int CH_W    = 3;
  localparam int COND_W  = 3;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [NUM_CH-1:0] RST_CH   = 8'h00;
  localparam logic              RST_BIT  = 1'h0;

  // ********************************************************************
  // pattern slice conditions
  // ********************************************************************
  typedef enum logic [COND_W-1:0] {
    PIM_COND_ONE          = 3'b000,
    PIM_COND_STICKY_RISE  = 3'b001,
    PIM_COND_STICKY_FALL  = 3'b010,
    PIM_COND_STICKY_ANY   = 3'b011,
    PIM_COND_HIGH         = 3'b100,
    PIM_COND_LOW          = 3'b101,
    PIM_COND_ZERO         = 3'b110,
    PIM_COND_EDGE_NOW     = 3'b111
  } pim_cond_type;

endpackage

// [logic/pim_chan_if.sv]
// synchronised channel levels and edges passed from the input stage
interface pim_chan_if #(parameter int N = 8);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport drv (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface

// [logic/pim_input_sync.sv]
// pin selection, synchroniser and edge detection for each channel
module pim_input_sync
  import pim_pkg::*;
#(
  parameter int N_PAD = NUM_PAD,
  parameter int N_CH  = NUM_CH
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic [N_PAD-1:0]        pad_in,
  input  wire logic [N_CH*SEL_W-1:0]   pin_select,
  pim_chan_if.drv                      chan
);

  // ********************************************************************
  // selection
  // ********************************************************************
  logic [N_CH-1:0] picked;
  logic [N_CH-1:0] sync_a;
  logic [N_CH-1:0] sync_b;
  logic [N_CH-1:0] sync_c;

  // taps the pad before the switch matrix, so any pin function is visible
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_pick
      wire [SEL_W-1:0] sel = pin_select[g*SEL_W +: SEL_W];
      assign picked[g] = (int'(sel) < N_PAD) ? pad_in[sel] : 1'b0; // R05 R01
    end
  endgenerate

  // ********************************************************************
  // synchroniser; sync_a is read only by sync_b
  // ********************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_a <= RST_CH;
      sync_b <= RST_CH;
      sync_c <= RST_CH;
    end else begin
      sync_a <= picked; // R15
      sync_b <= sync_a; // R15
      sync_c <= sync_b;
    end
  end

  assign chan.level = sync_b;
  assign chan.rise  = sync_b & ~sync_c;
  assign chan.fall  = ~sync_b & sync_c;

  // ********************************************************************
  // checks
  // ********************************************************************
  a_sync_two_stage: assert property (@(posedge sys_clk) disable iff (rst) // R15
    !$past(rst, 2) |-> chan.level == $past(picked, 2))
    else $error("synchronised level does not trail the pad by two cycles");

endmodule

// [logic/pim_engine.sv]
// pin interrupt and pattern match engine top level
//
// Contract
// R01: Up to eight channels each take any digital pad as an interrupt source.
// R02: Every channel drives its own interrupt line, none shared.
// R03: An edge channel requests on rising, falling or both edges as set per channel.
// R04: A level channel requests while its pin sits at the chosen high or low level.
// R05: Pad choice comes from configuration and ignores the pad's current function.
// R06: All control bits are plain inputs acting in the very next cycle.
// R07: A pin interrupt request also raises a wake request.
// R08: In pattern use up to eight channel inputs feed one boolean expression.
// R09: Each slice tests a level or a transition of its chosen channel.
// R10: Each product term raises its own interrupt when it becomes true.
// R11: When enabled, any match pulses the processor event notification.
// R12: The event notification may also be routed to a pin output.
// R13: Pattern use never raises the wake request.
// R14: The match result is offered as a level output for the switch matrix.
// R15: Selected pads pass a two-flop synchroniser before any detection.
module pim_engine
  import pim_pkg::*;
#(
  parameter int N_PAD = NUM_PAD
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic [N_PAD-1:0]         pad_in,
  input  wire logic [NUM_CH*SEL_W-1:0]  pin_select,
  input  wire logic [NUM_CH-1:0]        level_mode,
  input  wire logic [NUM_CH-1:0]        rise_enable,
  input  wire logic [NUM_CH-1:0]        fall_enable,
  input  wire logic [NUM_CH-1:0]        pend_clear,
  input  wire logic                     pattern_mode,
  input  wire logic [NUM_CH*CH_W-1:0]   slice_src,
  input  wire logic [NUM_CH*COND_W-1:0] slice_cond,
  input  wire logic [NUM_CH-1:0]        slice_end,
  input  wire logic                     sticky_clear,
  input  wire logic                     event_enable,
  input  wire logic                     event_to_pin,
  output logic      [NUM_CH-1:0]        irq,
  output logic                          wake_req,
  output logic                          cpu_event_notify,
  output logic                          cpu_event_pin,
  output logic                          pattern_match_out,
  output logic      [NUM_CH-1:0]        rise_seen,
  output logic      [NUM_CH-1:0]        fall_seen
);

  // ********************************************************************
  // declarations
  // ********************************************************************
  pim_chan_if #(.N(NUM_CH)) chan ();

  logic [NUM_CH-1:0] pending;
  logic [NUM_CH-1:0] next_pending;
  logic [NUM_CH-1:0] next_irq;
  logic [NUM_CH-1:0] edge_hit;
  logic [NUM_CH-1:0] level_req;
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] sticky;
  logic [NUM_CH-1:0] next_sticky;
  logic [NUM_CH-1:0] sticky_hit;
  logic [NUM_CH-1:0] cond_ok;
  logic [NUM_CH-1:0] acc;
  logic [NUM_CH-1:0] end_eff;
  logic [NUM_CH-1:0] term;
  logic [NUM_CH-1:0] term_q;
  logic [NUM_CH-1:0] term_rise;
  logic              any_rise;
  logic              next_event;

  // ********************************************************************
  // input stage
  // ********************************************************************
  pim_input_sync #(
    .N_PAD (N_PAD),
    .N_CH  (NUM_CH)
  ) u_sync (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pad_in     (pad_in),
    .pin_select (pin_select),
    .chan       (chan.drv)
  );

  // ********************************************************************
  // slice evaluation
  // ********************************************************************
  function automatic logic slice_eval(input logic [COND_W-1:0] code,
                                      input logic lvl,
                                      input logic rs,
                                      input logic fl,
                                      input logic stk);
    logic r;
    r = 1'b0;
    unique case (pim_cond_type'(code))
      PIM_COND_ONE:         r = 1'b1;
      PIM_COND_STICKY_RISE: r = stk;
      PIM_COND_STICKY_FALL: r = stk;
      PIM_COND_STICKY_ANY:  r = stk;
      PIM_COND_HIGH:        r = lvl;
      PIM_COND_LOW:         r = ~lvl;
      PIM_COND_ZERO:        r = 1'b0;
      PIM_COND_EDGE_NOW:    r = rs | fl;
    endcase
    return r;
  endfunction

  function automatic logic sticky_event(input logic [COND_W-1:0] code,
                                        input logic rs,
                                        input logic fl);
    logic r;
    r = 1'b0;
    unique case (pim_cond_type'(code))
      PIM_COND_STICKY_RISE: r = rs;
      PIM_COND_STICKY_FALL: r = fl;
      PIM_COND_STICKY_ANY:  r = rs | fl;
      PIM_COND_ONE,
      PIM_COND_HIGH,
      PIM_COND_LOW,
      PIM_COND_ZERO,
      PIM_COND_EDGE_NOW:    r = 1'b0;
    endcase
    return r;
  endfunction

  genvar j;
  generate
    for (j = 0; j < NUM_CH; j++) begin : g_slice
      wire [CH_W-1:0]   src  = slice_src[j*CH_W +: CH_W];
      wire [COND_W-1:0] code = slice_cond[j*COND_W +: COND_W];
      wire              lvl  = chan.level[src];
      wire              rs   = chan.rise[src];
      wire              fl   = chan.fall[src];
      assign sticky_hit[j] = sticky_event(code, rs, fl); // R09
      assign cond_ok[j]    = slice_eval(code, lvl, rs, fl, sticky[j]); // R09 R08
      if (j == 0) begin : g_first
        assign acc[j] = cond_ok[j];
      end else begin : g_next
        // a slice after an endpoint opens a new product term
        assign acc[j] = cond_ok[j] & (slice_end[j-1] | acc[j-1]);
      end
      if (j == NUM_CH - 1) begin : g_last
        assign end_eff[j] = 1'b1;
      end else begin : g_mid
        assign end_eff[j] = slice_end[j];
      end
    end
  endgenerate

  assign term        = acc & end_eff & {NUM_CH{pattern_mode}}; // R10
  assign term_rise   = term & ~term_q; // R10
  assign any_rise    = |term_rise;
  assign next_sticky = sticky_hit | (sticky & ~{NUM_CH{sticky_clear}});

  // ********************************************************************
  // per channel requests
  // ********************************************************************
  assign edge_hit  = ~level_mode & ((rise_enable & chan.rise) | (fall_enable & chan.fall)); // R03
  // fall_enable doubles as polarity in level mode: 1 means high active
  assign level_req = level_mode & rise_enable & ~(chan.level ^ fall_enable); // R04
  assign hit       = pattern_mode ? term_rise : edge_hit;
  // a new hit in the clearing cycle keeps the request pending
  assign next_pending = hit | (pending & ~pend_clear); // R06
  assign next_irq  = pattern_mode ? next_pending
                                  : ((level_mode & level_req) | (~level_mode & next_pending)); // R02
  assign next_event = event_enable & any_rise; // R11

  // ********************************************************************
  // state
  // ********************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending <= RST_CH;
      sticky  <= RST_CH;
      term_q  <= RST_CH;
    end else begin
      pending <= next_pending;
      sticky  <= next_sticky; // R09
      term_q  <= term;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  // wake is only as good as sys_clk: the clock gate above must keep it alive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq               <= RST_CH;
      wake_req          <= RST_BIT;
      cpu_event_notify  <= RST_BIT;
      cpu_event_pin     <= RST_BIT;
      pattern_match_out <= RST_BIT;
      rise_seen         <= RST_CH;
      fall_seen         <= RST_CH;
    end else begin
      irq               <= next_irq; // R01 R02
      wake_req          <= ~pattern_mode & (|next_irq); // R07 R13
      cpu_event_notify  <= next_event; // R11
      cpu_event_pin     <= next_event & event_to_pin; // R12
      pattern_match_out <= |term; // R14
      rise_seen         <= chan.rise | (rise_seen & ~pend_clear);
      fall_seen         <= chan.fall | (fall_seen & ~pend_clear);
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_edge_sets_irq: assert property ( // R03
    (!pattern_mode && |edge_hit) |=> ((irq & $past(edge_hit)) == $past(edge_hit)))
    else $error("edge hit did not raise its channel request");

  a_level_follows_pin: assert property ( // R04
    (!pattern_mode && $stable(level_mode)) |=>
      ((irq & $past(level_mode)) == $past(level_req)))
    else $error("level request does not follow pin level");

  a_set_beats_clear: assert property ( // R06
    (|(hit & pend_clear)) |=> ((pending & $past(hit)) == $past(hit)))
    else $error("request lost in clearing cycle");

  a_clear_drops_pending: assert property ( // R06
    (|(pend_clear & ~hit)) |=> ((pending & $past(pend_clear & ~hit)) == '0))
    else $error("cleared request stayed pending");

  a_term_raises_irq: assert property ( // R10
    (pattern_mode && |term_rise) ##1 pattern_mode |->
      ((irq & $past(term_rise)) == $past(term_rise)))
    else $error("product term did not raise its request");

  a_event_gated: assert property ( // R11
    cpu_event_notify |-> $past(event_enable) && $past(any_rise))
    else $error("event notify without enabled match");

  a_event_is_pulse_cause: assert property ( // R11
    (event_enable && any_rise) |=> cpu_event_notify)
    else $error("enabled match gave no event notify");

  a_event_pin_route: assert property ( // R12
    cpu_event_pin |-> (cpu_event_notify && $past(event_to_pin)))
    else $error("event pin active without route or notify");

  a_pattern_no_wake: assert property ( // R13
    pattern_mode |=> !wake_req)
    else $error("pattern use raised wake request");

  a_wake_from_irq: assert property ( // R07
    (!pattern_mode && |next_irq) |=> wake_req && |irq)
    else $error("pin request gave no wake request");

  a_match_out: assert property ( // R14
    !$past(rst) |-> pattern_match_out == $past(|term))
    else $error("match output does not follow terms");

  a_sticky_set_wins: assert property ( // R09
    (|sticky_hit) |=> ((sticky & $past(sticky_hit)) == $past(sticky_hit)))
    else $error("sticky slice lost its event");

  a_sticky_clears: assert property ( // R09
    (sticky_clear && !(|sticky_hit)) |=> (sticky == '0))
    else $error("sticky slice survived its clear");

  a_pend_needs_hit: assert property ( // R03
    !(|hit) |=> ((pending & ~$past(pending)) == '0))
    else $error("request set without a hit");

  a_level_disabled: assert property ( // R04
    !pattern_mode |=> ((irq & $past(level_mode & ~rise_enable)) == '0))
    else $error("disabled level channel raised a request");

  a_irq_from_term: assert property ( // R10
    pattern_mode |=> ((irq & ~$past(pending)) == $past(term_rise & ~pending)))
    else $error("pattern request without a rising term");

  a_edge_irq_pending: assert property ( // R02
    !pattern_mode |=> ((irq & ~$past(level_mode)) == (pending & ~$past(level_mode))))
    else $error("edge channel line differs from its pending flag");

  a_wake_needs_irq: assert property ( // R07
    wake_req |-> (|irq))
    else $error("wake request with no channel request");

  a_rise_seen_holds: assert property ( // R03
    (|chan.rise) |=> ((rise_seen & $past(chan.rise)) == $past(chan.rise)))
    else $error("rising edge status lost");

  a_fall_seen_holds: assert property ( // R03
    (|chan.fall) |=> ((fall_seen & $past(chan.fall)) == $past(chan.fall)))
    else $error("falling edge status lost");

  a_event_pin_off: assert property ( // R12
    !event_to_pin |=> !cpu_event_pin)
    else $error("event pin active while not routed");

endmodule

// [test/pim_cpu_model.sv]
// behavioural model of the processor side: services requests and counts events
module pim_cpu_model
  import pim_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [NUM_CH-1:0] irq,
  input  wire logic              cpu_event_notify,
  input  wire logic              ack_go,
  input  wire logic [NUM_CH-1:0] ack_mask,
  output logic      [NUM_CH-1:0] pend_clear,
  output int                     event_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************************
  // service and event capture
  // ********************************************************************
  // only lines that are pending get a clear, as a handler would do
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_clear  <= '0;
      event_count <= 0;
    end else begin
      pend_clear <= ack_go ? (ack_mask & irq) : '0;
      if (cpu_event_notify === 1'h1) begin
        event_count <= event_count + 1;
      end
    end
  end
endmodule

// [test/pim_engine_bench.sv]
// self-checking bench of the pin interrupt and pattern match engine
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %s expected %h got %h", nm, exp, got); end end
module pim_engine_bench;
  import pim_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     sys_clk = 1'h0;
  logic                     rst = 1'h1;
  logic [NUM_PAD-1:0]       pad_in = 18'h00400;
  logic [NUM_CH*SEL_W-1:0]  pin_select = {5'h00, 5'h00, 5'h0B, 5'h0A, 5'h09, 5'h03, 5'h11, 5'h05};
  logic [NUM_CH-1:0]        level_mode = 8'h38;
  logic [NUM_CH-1:0]        rise_enable = 8'h1D;
  logic [NUM_CH-1:0]        fall_enable = 8'h0E;
  logic                     pattern_mode = 1'h0;
  logic [NUM_CH*CH_W-1:0]   slice_src = 24'h000008;
  logic [NUM_CH*COND_W-1:0] slice_cond = 24'h000000;
  logic [NUM_CH-1:0]        slice_end = 8'h83;
  logic                     event_enable = 1'h1;
  logic                     event_to_pin = 1'h1;
  logic                     sticky_clear = 1'h0;
  logic                     ack_go = 1'h0;
  logic [NUM_CH-1:0]        ack_mask = 8'h00;
  logic [NUM_CH-1:0]        pend_clear;
  logic [NUM_CH-1:0]        irq;
  logic                     wake_req;
  logic                     cpu_event_notify;
  logic                     cpu_event_pin;
  logic                     pattern_match_out;
  logic [NUM_CH-1:0]        rise_seen;
  logic [NUM_CH-1:0]        fall_seen;
  int                       event_count;
  int                       err_count = 0;
  int                       comparisons = 0;
  int                       cycles = 0;

  always #5 sys_clk = ~sys_clk;

  pim_engine dut (.sys_clk(sys_clk), .rst(rst), .pad_in(pad_in), .pin_select(pin_select),
    .level_mode(level_mode), .rise_enable(rise_enable), .fall_enable(fall_enable),
    .pend_clear(pend_clear), .pattern_mode(pattern_mode), .slice_src(slice_src),
    .slice_cond(slice_cond), .slice_end(slice_end), .sticky_clear(sticky_clear),
    .event_enable(event_enable), .event_to_pin(event_to_pin), .irq(irq),
    .wake_req(wake_req), .cpu_event_notify(cpu_event_notify), .cpu_event_pin(cpu_event_pin),
    .pattern_match_out(pattern_match_out), .rise_seen(rise_seen), .fall_seen(fall_seen));

  pim_cpu_model cpu (.sys_clk(sys_clk), .rst(rst), .irq(irq),
    .cpu_event_notify(cpu_event_notify), .ack_go(ack_go), .ack_mask(ack_mask),
    .pend_clear(pend_clear), .event_count(event_count));

  // ********************************************************************
  // tasks
  // ********************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // request a clear from the processor model and let it land
  task automatic service(input logic [NUM_CH-1:0] m);
    ack_mask = m;
    ack_go = 1'h1;
    step(1);
    ack_go = 1'h0;
    step(2);
  endtask

  task automatic end_sim;
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a hang costs at most a few thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    for (int j = 2; j < NUM_CH; j++) begin
      slice_cond[COND_W*j+:COND_W] = PIM_COND_ZERO;
    end
    slice_cond[2:0] = PIM_COND_HIGH;
    slice_cond[5:3] = PIM_COND_LOW;
    step(20);
    rst = 1'h0;
    step(6);
    `CHK("idle irq", 8'h00, irq)
    // rising pads: ch0 rise-only, ch1 fall-only ignores it, ch2 both, ch5 level disabled
    pad_in = pad_in | 18'h20828;
    step(2);
    `CHK("irq early", 8'h00, irq)
    step(1);
    `CHK("rise irq", 8'h05, irq)
    `CHK("wake", 1'h1, wake_req)
    service(8'h05);
    `CHK("cleared irq", 8'h00, irq)
    `CHK("wake off", 1'h0, wake_req)
    // falling pads: ch1 fall-only, ch2 both, ch0 rise-only ignores it
    pad_in = pad_in & ~18'h20028;
    step(3);
    `CHK("fall irq", 8'h06, irq)
    service(8'h06);
    `CHK("rise seen", 8'h30, rise_seen)
    `CHK("fall seen", 8'h01, fall_seen)
    // levels: ch3 high active, ch4 low active
    pad_in = (pad_in | 18'h00200) & ~18'h00400;
    step(3);
    `CHK("level irq", 8'h18, irq)
    pad_in = (pad_in & ~18'h00200) | 18'h00400;
    step(3);
    `CHK("level off", 8'h00, irq)
    // pattern use: term0 = ch0 high, term1 = ch1 low
    pad_in = pad_in | 18'h20000;
    step(4);
    pattern_mode = 1'h1;
    step(4);
    service(8'hFF);
    `CHK("no match", 1'h0, pattern_match_out)
    pad_in = pad_in | 18'h00020;
    step(3);
    `CHK("term0 irq", 8'h01, irq)
    `CHK("notify", 1'h1, cpu_event_notify)
    `CHK("event pin", 1'h1, cpu_event_pin)
    `CHK("match out", 1'h1, pattern_match_out)
    `CHK("no wake", 1'h0, wake_req)
    step(1);
    `CHK("notify pulse", 1'h0, cpu_event_notify)
    event_enable = 1'h0;
    pad_in = pad_in & ~18'h20000;
    step(3);
    `CHK("term1 irq", 8'h03, irq)
    `CHK("notify gated", 1'h0, cpu_event_notify)
    `CHK("no wake 2", 1'h0, wake_req)
    step(2);
    `CHK("event count", 1, event_count)
    // transitions: term2 = sticky rise of ch2, term3 = ch2 edge now; terms 0 and 1 go false
    service(8'h03);
    slice_src[11:6] = 6'h12;
    slice_cond[8:6] = PIM_COND_STICKY_RISE;
    slice_cond[11:9] = PIM_COND_EDGE_NOW;
    slice_end[3:2] = 2'h3;
    event_enable = 1'h1;
    event_to_pin = 1'h0;
    pad_in = (pad_in & ~18'h00020) | 18'h20008;
    step(3);
    `CHK("edge now irq", 8'h08, irq)
    `CHK("notify again", 1'h1, cpu_event_notify)
    `CHK("pin unrouted", 1'h0, cpu_event_pin)
    step(1);
    `CHK("sticky irq", 8'h0C, irq)
    `CHK("match held", 1'h1, pattern_match_out)
    sticky_clear = 1'h1;
    step(1);
    sticky_clear = 1'h0;
    step(2);
    `CHK("sticky cleared", 1'h0, pattern_match_out)
    // ch2 falls as the processor clears both lines: the new hit must survive
    pad_in = pad_in & ~18'h00008;
    step(1);
    service(8'h0C);
    `CHK("set beats clear", 8'h08, irq)
    `CHK("event count all", 4, event_count)
    end_sim();
  end
endmodule
